//--- include/nano_dispatch_pkg.sv
// Summary of operation
// [RULE_01] dispatch loads counter top bits with page
// [RULE_02] dispatch loads counter low bits with opcode
// [RULE_03] dispatch saves low eleven bus bits
// [RULE_04] parameter load clears parameter register top bits
// [RULE_05] parameter load writes saved eleven bits low
// [RULE_06] parameter readable in first step after load
// [RULE_07] 128 opcode entries per page
// [RULE_08] entry without permit bit raises program check
// [RULE_09] about one second idle raises program check
// [RULE_10] nanobranch leaves sequence counter untouched
// [RULE_11] nanobranch outranks every interrupt level
// [RULE_12] hold bit keeps covered fields across gate
// [RULE_13] holds ignored on micro entry or check
// [RULE_14] hold one and hold two field groups
// [RULE_15] avoid hold together with interrupt permits
// [RULE_16] step increments counter, jump loads successor
// [RULE_17] pending level needs its permit bit set
// [RULE_18] counter is the lowest fetch source
// [RULE_19] time-out restarts on dispatch, fires once
package nano_dispatch_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_NS      = 20;
  localparam int TIMEOUT_NS  = 1000000000;
  localparam int TIMEOUT_CYC = TIMEOUT_NS / CLK_NS;

  // ------------------------------------------------------------
  // widths and field positions
  // ------------------------------------------------------------
  localparam int NSC_W      = 10;
  localparam int PAGE_W     = 3;
  localparam int OPC_W      = 7;
  localparam int PARM_W     = 11;
  localparam int CS_W       = 18;
  localparam int FLD_W      = 6;
  localparam int LVL_N      = 30;
  localparam int NANO_LVL_N = 10;
  localparam int LVL_W      = 5;
  localparam int STS_W      = 2;
  localparam int STS_ENTRY  = 0;
  localparam int STS_TMO    = 1;

  // ------------------------------------------------------------
  // register map and reset values
  // ------------------------------------------------------------
  localparam logic [7:0]        ADDR_PAGE  = 8'h00;
  localparam logic [7:0]        ADDR_STS   = 8'h04;
  localparam logic [7:0]        ADDR_MASK  = 8'h08;
  localparam logic [7:0]        ADDR_PARAM = 8'h0c;
  localparam logic [7:0]        ADDR_NSC   = 8'h10;
  localparam logic [PAGE_W-1:0] PAGE_RST   = 3'h0;
  localparam logic [STS_W-1:0]  MASK_RST   = 2'h0;

  typedef enum logic [1:0] {
    SRC_SEQ    = 2'b00,
    SRC_IRQ    = 2'b01,
    SRC_BRANCH = 2'b11
  } fetch_src_t;

  typedef enum logic [1:0] {
    TMO_IDLE = 2'b00,
    TMO_RUN  = 2'b01,
    TMO_DONE = 2'b11
  } tmo_state_t;

  typedef struct packed {
    logic [NSC_W-1:0] succ;
    logic [FLD_W-1:0] alu;
    logic [FLD_W-1:0] shc;
    logic [FLD_W-1:0] sha;
    logic [FLD_W-1:0] ssel;
    logic [FLD_W-1:0] port;
    logic [FLD_W-1:0] bidx;
    logic             entry_permit;
    logic             hold1;
    logic             hold2;
    logic             branch;
    logic             permit_nano;
    logic             permit_micro;
  } kvec_t;

  typedef struct packed {
    logic             valid;
    fetch_src_t       src;
    logic [LVL_W-1:0] level;
    logic [NSC_W-1:0] addr;
  } fetch_t;
endpackage

//--- core/micro_timeout.sv
`timescale 1ns/100ps
module micro_timeout #(
  parameter int unsigned CYCLES = nano_dispatch_pkg::TIMEOUT_CYC
) (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic ce_i,
  input  wire logic restart_i,
  output logic      expire_o
);
  typedef struct packed {
    nano_dispatch_pkg::tmo_state_t st;
    logic [31:0]                   cnt;
    logic                          expire;
  } tmo_st_t;

  tmo_st_t st_reg;
  tmo_st_t st_next;

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  // idle until the first dispatch: no check before any opcode
  always_comb begin
    st_next        = st_reg;
    // a frozen expiry stays up so the core cannot miss it
    if (ce_i) begin
      st_next.expire = 1'b0;
      if (restart_i) begin
        st_next.st  = nano_dispatch_pkg::TMO_RUN; // RULE_19
        st_next.cnt = 32'h0000_0000;
      end else begin
        case (st_reg.st)
          nano_dispatch_pkg::TMO_RUN: begin
            if (st_reg.cnt == 32'(CYCLES - 1)) begin
              st_next.st     = nano_dispatch_pkg::TMO_DONE; // RULE_09
              st_next.expire = 1'b1;
            end else begin
              st_next.cnt = st_reg.cnt + 32'h0000_0001;
            end
          end
          nano_dispatch_pkg::TMO_DONE: st_next.st = st_reg.st;
          default:                     st_next.st = st_reg.st;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= '{nano_dispatch_pkg::TMO_IDLE, 32'h0000_0000, 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign expire_o = st_reg.expire;

  property p_tmo_once;
    @(posedge clk_i) disable iff (!reset_n_i)
    (ce_i && expire_o) |=> !expire_o;
  endproperty
  a_tmo_once: assert property (p_tmo_once) // RULE_19
    else $error("time-out fired twice in a row");

  property p_tmo_restart;
    @(posedge clk_i) disable iff (!reset_n_i)
    (ce_i && restart_i) |=> (st_reg.cnt == 32'h0000_0000) && !expire_o;
  endproperty
  a_tmo_restart: assert property (p_tmo_restart) // RULE_19
    else $error("dispatch did not restart time-out");
endmodule

//--- core/micro_opcode_dispatch_sequencer.sv
`timescale 1ns/100ps
module micro_opcode_dispatch_sequencer #(
  parameter int unsigned TIMEOUT_CYCLES = nano_dispatch_pkg::TIMEOUT_CYC
) (
  input  wire logic                                   CLK_I,
  input  wire logic                                   RESET_N_I,
  input  wire logic                                   CE_I,
  input  wire logic                                   DISPATCH_I,
  input  wire logic                                   JUMP_I,
  input  wire logic                                   SEQ_I,
  input  wire logic                                   LOAD_PARAM_I,
  input  wire logic                                   GATE_I,
  input  wire logic                                   FETCH_I,
  input  wire logic [nano_dispatch_pkg::CS_W-1:0]     CS_OUT_I,
  input  wire nano_dispatch_pkg::kvec_t               NW_I,
  input  wire logic [nano_dispatch_pkg::LVL_N-1:0]    IRQ_PEND_I,
  input  wire logic [7:0]                             PADDR_I,
  input  wire logic                                   PSEL_I,
  input  wire logic                                   PENABLE_I,
  input  wire logic                                   PWRITE_I,
  input  wire logic [31:0]                            PWDATA_I,
  output nano_dispatch_pkg::kvec_t                    K_O,
  output logic [nano_dispatch_pkg::NSC_W-1:0]         NSC_O,
  output logic [nano_dispatch_pkg::CS_W-1:0]          PARAM_O,
  output nano_dispatch_pkg::fetch_t                   FETCH_O,
  output logic                                        PCHK_O,
  output logic                                        IRQ_O,
  output logic [31:0]                                 PRDATA_O,
  output logic                                        PREADY_O,
  output logic                                        PSLVERR_O
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [nano_dispatch_pkg::NSC_W-1:0]  nsc;
    logic [nano_dispatch_pkg::PAGE_W-1:0] page;
    logic [nano_dispatch_pkg::PARM_W-1:0] saved;
    logic [nano_dispatch_pkg::CS_W-1:0]   param;
    nano_dispatch_pkg::kvec_t             k;
    logic                                 pchk_entry;
    logic                                 pchk;
    logic [nano_dispatch_pkg::STS_W-1:0]  sts;
    logic [nano_dispatch_pkg::STS_W-1:0]  mask;
    nano_dispatch_pkg::fetch_t            fetch;
    logic                                 armed;
    logic [31:0]                          rdata;
    logic                                 rerr;
  } core_st_t;

  core_st_t st_reg;
  core_st_t st_next;
  logic     tmo_expire;
  logic     pready_c;

  // ------------------------------------------------------------
  // time-out watchdog
  // ------------------------------------------------------------
  micro_timeout #(
    .CYCLES    (TIMEOUT_CYCLES)
  ) u_timeout (
    .clk_i     (CLK_I),
    .reset_n_i (RESET_N_I),
    .ce_i      (CE_I),
    .restart_i (DISPATCH_I),
    .expire_o  (tmo_expire)
  );

  // ------------------------------------------------------------
  // apb handshake
  // ------------------------------------------------------------
  // armed guards against read data captured while frozen
  assign pready_c  = PSEL_I & PENABLE_I & CE_I & st_reg.armed;
  assign PREADY_O  = pready_c;
  assign PSLVERR_O = pready_c & st_reg.rerr;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic                                  keep;
    logic                                  entry_bad;
    logic [nano_dispatch_pkg::LVL_N-1:0]   permit;
    logic [nano_dispatch_pkg::LVL_N-1:0]   act;
    logic [nano_dispatch_pkg::LVL_W-1:0]   lvl;
    logic [nano_dispatch_pkg::STS_W-1:0]   set;
    logic [nano_dispatch_pkg::STS_W-1:0]   clr;
    keep      = 1'b0;
    entry_bad = 1'b0;
    permit    = '0;
    act       = '0;
    lvl       = '0;
    set       = '0;
    clr       = '0;
    st_next   = st_reg;
    if (CE_I) begin
      // pulses decay on enabled cycles only, a freeze keeps them
      st_next.fetch.valid = 1'b0;
      st_next.pchk        = 1'b0;
      // sequence counter; dispatch beats jump, jump beats step
      if (DISPATCH_I) begin
        st_next.nsc[nano_dispatch_pkg::NSC_W-1 -: nano_dispatch_pkg::PAGE_W] =
          st_reg.page; // RULE_01
        st_next.nsc[nano_dispatch_pkg::OPC_W-1:0] =
          CS_OUT_I[nano_dispatch_pkg::CS_W-1 -: nano_dispatch_pkg::OPC_W]; // RULE_02 RULE_07
        st_next.saved = CS_OUT_I[nano_dispatch_pkg::PARM_W-1:0]; // RULE_03
      end else if (JUMP_I) begin
        st_next.nsc = st_reg.k.succ; // RULE_16
      end else if (SEQ_I) begin
        st_next.nsc = st_reg.nsc + 1'b1; // RULE_16
      end

      // parameter register, visible from the next step on
      if (LOAD_PARAM_I) begin
        st_next.param = {7'h00, st_reg.saved}; // RULE_04 RULE_05 RULE_06
      end

      // gating a new nanoword into the control matrix
      if (GATE_I) begin
        keep      = !LOAD_PARAM_I && !st_reg.pchk_entry; // RULE_13
        st_next.k = NW_I;
        if (keep && st_reg.k.hold1) begin
          st_next.k.alu  = st_reg.k.alu; // RULE_12 RULE_14
          st_next.k.shc  = st_reg.k.shc;
          st_next.k.sha  = st_reg.k.sha;
          st_next.k.ssel = st_reg.k.ssel;
        end
        if (keep && st_reg.k.hold2) begin
          st_next.k.port = st_reg.k.port; // RULE_12 RULE_14
          st_next.k.bidx = st_reg.k.bidx;
        end
        st_next.pchk_entry = 1'b0;
        entry_bad = LOAD_PARAM_I && !NW_I.entry_permit; // RULE_08
      end

      // program check; the next gated word is its entry
      if (entry_bad || tmo_expire) begin
        st_next.pchk       = 1'b1; // RULE_08 RULE_09
        st_next.pchk_entry = 1'b1;
      end

      // fetch source selection, counter never touched here
      if (FETCH_I) begin
        permit = {{(nano_dispatch_pkg::LVL_N -
                    nano_dispatch_pkg::NANO_LVL_N){st_reg.k.permit_micro}},
                  {nano_dispatch_pkg::NANO_LVL_N{st_reg.k.permit_nano}}};
        act = IRQ_PEND_I & permit; // RULE_17
        for (int i = nano_dispatch_pkg::LVL_N - 1; i >= 0; i--) begin
          if (act[i]) begin
            lvl = nano_dispatch_pkg::LVL_W'(i);
          end
        end
        st_next.fetch.valid = 1'b1;
        st_next.fetch.level = lvl;
        if (st_reg.k.branch) begin
          st_next.fetch.src  = nano_dispatch_pkg::SRC_BRANCH; // RULE_10 RULE_11
          st_next.fetch.addr = st_reg.k.succ;
        end else if (|act) begin
          st_next.fetch.src  = nano_dispatch_pkg::SRC_IRQ;
          st_next.fetch.addr = st_reg.nsc;
        end else begin
          st_next.fetch.src  = nano_dispatch_pkg::SRC_SEQ; // RULE_18
          st_next.fetch.addr = st_reg.nsc;
        end
      end

      // apb read capture and write decode
      st_next.armed = PSEL_I & ~pready_c;
      if (PSEL_I) begin
        st_next.rerr  = 1'b0;
        st_next.rdata = 32'h0000_0000;
        case (PADDR_I)
          nano_dispatch_pkg::ADDR_PAGE:  st_next.rdata[2:0] = st_reg.page;
          nano_dispatch_pkg::ADDR_STS:   st_next.rdata[1:0] = st_reg.sts;
          nano_dispatch_pkg::ADDR_MASK:  st_next.rdata[1:0] = st_reg.mask;
          nano_dispatch_pkg::ADDR_PARAM: st_next.rdata[17:0] = st_reg.param;
          nano_dispatch_pkg::ADDR_NSC:   st_next.rdata[9:0] = st_reg.nsc;
          default:                       st_next.rerr = 1'b1;
        endcase
      end
      if (pready_c && PWRITE_I) begin
        case (PADDR_I)
          nano_dispatch_pkg::ADDR_PAGE: st_next.page = PWDATA_I[2:0];
          nano_dispatch_pkg::ADDR_STS:  clr = PWDATA_I[1:0];
          nano_dispatch_pkg::ADDR_MASK: st_next.mask = PWDATA_I[1:0];
          default:                      clr = '0;
        endcase
      end

      // sticky status, a new event beats a same-cycle clear
      set[nano_dispatch_pkg::STS_ENTRY] = entry_bad;
      set[nano_dispatch_pkg::STS_TMO]   = tmo_expire;
      st_next.sts = (st_reg.sts & ~clr) | set;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st_reg      <= '0;
      st_reg.page <= nano_dispatch_pkg::PAGE_RST;
      st_reg.mask <= nano_dispatch_pkg::MASK_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign K_O      = st_reg.k;
  assign NSC_O    = st_reg.nsc;
  assign PARAM_O  = st_reg.param;
  assign FETCH_O  = st_reg.fetch;
  assign PCHK_O   = st_reg.pchk;
  assign IRQ_O    = |(st_reg.sts & st_reg.mask);
  assign PRDATA_O = st_reg.rdata;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_page;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && DISPATCH_I) |=> (NSC_O[9:7] == $past(st_reg.page));
  endproperty
  a_page: assert property (p_page) // RULE_01
    else $error("dispatch page bits wrong");

  property p_opcode;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && DISPATCH_I) |=> (NSC_O[6:0] == $past(CS_OUT_I[17:11]));
  endproperty
  a_opcode: assert property (p_opcode) // RULE_02
    else $error("dispatch opcode bits wrong");

  property p_save;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && DISPATCH_I) |=> (st_reg.saved == $past(CS_OUT_I[10:0]));
  endproperty
  a_save: assert property (p_save) // RULE_03
    else $error("saved parameter not moved");

  property p_param;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && LOAD_PARAM_I) |=>
      (PARAM_O[17:11] == 7'h00) && (PARAM_O[10:0] == $past(st_reg.saved));
  endproperty
  a_param: assert property (p_param) // RULE_05
    else $error("parameter register load wrong");

  property p_entry;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && GATE_I && LOAD_PARAM_I && !NW_I.entry_permit)
      |=> PCHK_O && st_reg.sts[0];
  endproperty
  a_entry: assert property (p_entry) // RULE_08
    else $error("illegal entry not checked");

  property p_branch;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && FETCH_I && st_reg.k.branch && !DISPATCH_I && !JUMP_I && !SEQ_I)
      |=> (FETCH_O.src == nano_dispatch_pkg::SRC_BRANCH) && $stable(NSC_O);
  endproperty
  a_branch: assert property (p_branch) // RULE_10
    else $error("nanobranch lost or counter moved");

  property p_hold;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && GATE_I && st_reg.k.hold1 && !LOAD_PARAM_I && !st_reg.pchk_entry)
      |=> (K_O.alu == $past(K_O.alu)) && (K_O.ssel == $past(K_O.ssel));
  endproperty
  a_hold: assert property (p_hold) // RULE_12
    else $error("held field changed on gate");

  property p_nohold;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && GATE_I && LOAD_PARAM_I) |=> (K_O == $past(NW_I));
  endproperty
  a_nohold: assert property (p_nohold) // RULE_13
    else $error("hold not ignored on micro entry");

  property p_seq;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && SEQ_I && !DISPATCH_I && !JUMP_I)
      |=> (NSC_O == $past(NSC_O) + 10'h001);
  endproperty
  a_seq: assert property (p_seq) // RULE_16
    else $error("sequence step wrong");

  property p_default;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && FETCH_I && !st_reg.k.branch && !st_reg.k.permit_nano &&
     !st_reg.k.permit_micro)
      |=> (FETCH_O.src == nano_dispatch_pkg::SRC_SEQ) &&
          (FETCH_O.addr == $past(NSC_O));
  endproperty
  a_default: assert property (p_default) // RULE_17
    else $error("unpermitted interrupt took fetch");

  property p_jump;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && JUMP_I && !DISPATCH_I) |=> (NSC_O == $past(K_O.succ));
  endproperty
  a_jump: assert property (p_jump) // RULE_16
    else $error("jump lost");

  property p_chk_entry;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && GATE_I && st_reg.pchk_entry) |=> (K_O == $past(NW_I));
  endproperty
  a_chk_entry: assert property (p_chk_entry) // RULE_13
    else $error("hold kept on check entry");

  property p_irq_take;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && FETCH_I && !st_reg.k.branch && st_reg.k.permit_nano &&
     (|IRQ_PEND_I[9:0])) |=> (FETCH_O.src == nano_dispatch_pkg::SRC_IRQ);
  endproperty
  a_irq_take: assert property (p_irq_take) // RULE_17
    else $error("permitted level not taken");

  property p_seq_src;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && FETCH_I && !st_reg.k.branch && (IRQ_PEND_I == '0)) |=>
      (FETCH_O.src == nano_dispatch_pkg::SRC_SEQ) && (FETCH_O.addr == $past(NSC_O));
  endproperty
  a_seq_src: assert property (p_seq_src) // RULE_18
    else $error("counter not used as fetch source");

  property p_brprio;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && FETCH_I && st_reg.k.branch) |=>
      (FETCH_O.src == nano_dispatch_pkg::SRC_BRANCH) &&
      (FETCH_O.addr == $past(K_O.succ));
  endproperty
  a_brprio: assert property (p_brprio) // RULE_11
    else $error("nanobranch lost priority");

  property p_tmo_chk;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (CE_I && tmo_expire) |=> PCHK_O && st_reg.sts[1];
  endproperty
  a_tmo_chk: assert property (p_tmo_chk) // RULE_09
    else $error("time-out not checked");
endmodule

//--- tb/nanostore_model.sv
`timescale 1ns/100ps
module nanostore_model (
  input  wire logic [nano_dispatch_pkg::NSC_W-1:0] addr_i,
  output nano_dispatch_pkg::kvec_t                 word_o
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  nano_dispatch_pkg::kvec_t mem [1024];

  // unwritten words read as a pattern, a clean zero at every fourth address
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = {26{i[1:0]}};
    end
  end

  // word ready for gating once its address is presented
  assign word_o = mem[addr_i];
endmodule

//--- tb/micro_opcode_dispatch_sequencer_tb.sv
`timescale 1ns/100ps
module micro_opcode_dispatch_sequencer_tb;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam int TO = 400;
  logic                      clk, rst_n, dsp, jmp, seq, ldp, gat, fet, ce;
  logic                      psel, pen, pwr, pchk, irq, rdy, err, re;
  logic [7:0]                paddr;
  logic [31:0]               pwd, prd, rq;
  logic [17:0]               cs, prm;
  logic [29:0]               pend;
  logic [9:0]                nsc;
  nano_dispatch_pkg::kvec_t  nw, k, w1, w2, w3, w4, e;
  nano_dispatch_pkg::fetch_t fo;
  int                        errors, n_compared, c;

  micro_opcode_dispatch_sequencer #(.TIMEOUT_CYCLES(TO)) i_dut (
    .CLK_I(clk), .RESET_N_I(rst_n), .CE_I(ce), .DISPATCH_I(dsp),
    .JUMP_I(jmp), .SEQ_I(seq), .LOAD_PARAM_I(ldp), .GATE_I(gat),
    .FETCH_I(fet), .CS_OUT_I(cs), .NW_I(nw), .IRQ_PEND_I(pend),
    .PADDR_I(paddr), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PWDATA_I(pwd), .K_O(k), .NSC_O(nsc), .PARAM_O(prm), .FETCH_O(fo),
    .PCHK_O(pchk), .IRQ_O(irq), .PRDATA_O(prd), .PREADY_O(rdy),
    .PSLVERR_O(err));

  nanostore_model i_ns (.addr_i(fo.addr), .word_o(nw));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [63:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  function automatic nano_dispatch_pkg::kvec_t mk(input logic [5:0] s,
                                                   input logic [5:0] f);
    mk = {4'h0, s, s + 6'h1, s + 6'h2, s + 6'h3, s + 6'h4, s + 6'h5,
          s + 6'h6, f};
  endfunction

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel  <= 1'b1;
    pen   <= 1'b0;
    paddr <= a;
    pwr   <= w;
    pwd   <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 16);
    if (rdy !== 1'b1) begin
      errors++;
      close_out;
    end
    rq = prd;
    re = err;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  // command mask order: dispatch jump step load gate fetch
  task automatic pulse(input logic [5:0] m, input logic [17:0] c);
    @(posedge clk);
    {dsp, jmp, seq, ldp, gat, fet} <= m;
    cs <= c;
    @(posedge clk);
    {dsp, jmp, seq, ldp, gat, fet} <= 6'h0;
    cs <= ~c;
    #1;
  endtask

  task automatic go(input logic [6:0] opc,
                    input nano_dispatch_pkg::kvec_t w, input logic micro);
    i_ns.mem[{3'h5, opc}] = w;
    pulse(6'h20, {opc, 11'h0});
    pulse(6'h01, 18'h0);
    pulse({3'h0, micro, 2'h2}, 18'h0);
  endtask

  task automatic step_in(input nano_dispatch_pkg::kvec_t w);
    i_ns.mem[nsc + 10'h1] = w;
    pulse(6'h08, 18'h0);
    pulse(6'h01, 18'h0);
    pulse(6'h02, 18'h0);
  endtask

  task automatic count_chk;
    c = 0;
    repeat (3) begin
      c += (pchk === 1'b1);
      @(posedge clk);
      #1;
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_dispatch;
    chk("counter", nsc, 10'h0);
    apb(nano_dispatch_pkg::ADDR_PAGE, 1'b0, 32'h0);
    chk("page", rq, {29'h0, nano_dispatch_pkg::PAGE_RST});
    apb(nano_dispatch_pkg::ADDR_MASK, 1'b0, 32'h0);
    chk("mask", rq, {30'h0, nano_dispatch_pkg::MASK_RST});
    apb(nano_dispatch_pkg::ADDR_PAGE, 1'b1, 32'h5);
    i_ns.mem[10'h2ff] = mk(6'h10, 6'h20);
    pulse(6'h20, {7'h7f, 11'h5a3});
    chk("counter", nsc, 10'h2ff);
    chk("param", prm, 18'h0);
    pulse(6'h01, 18'h0);
    chk("fetch addr", fo.addr, 10'h2ff);
    pulse(6'h06, 18'h0);
    chk("param", prm, {7'h0, 11'h5a3});
    chk("k vector", k, mk(6'h10, 6'h20));
    count_chk;
    chk("check pulses", c, 0);
    apb(nano_dispatch_pkg::ADDR_NSC, 1'b0, 32'h0);
    chk("counter reg", rq, 32'h2ff);
    apb(nano_dispatch_pkg::ADDR_PARAM, 1'b1, 32'h0);
    apb(nano_dispatch_pkg::ADDR_PARAM, 1'b0, 32'h0);
    chk("param reg", rq, 32'h5a3);
    apb(8'h14, 1'b1, 32'h1);
    chk("unmapped err", re, 1'b1);
    chk("unmapped data", rq, 32'h0);
    $display("t_dispatch done");
  endtask

  task automatic t_entry;
    go(7'h11, mk(6'h08, 6'h00), 1'b1);
    count_chk;
    chk("check pulses", c, 1);
    apb(nano_dispatch_pkg::ADDR_STS, 1'b0, 32'h0);
    chk("status", rq, 32'h1);
    #1 chk("irq masked", irq, 1'b0);
    apb(nano_dispatch_pkg::ADDR_MASK, 1'b1, 32'h1);
    #1 chk("irq", irq, 1'b1);
    apb(nano_dispatch_pkg::ADDR_STS, 1'b1, 32'h1);
    #1 chk("irq cleared", irq, 1'b0);
    apb(nano_dispatch_pkg::ADDR_STS, 1'b0, 32'h0);
    chk("status", rq, 32'h0);
    $display("t_entry done");
  endtask

  // holds never share a word with interrupt permits
  task automatic t_hold;
    w1 = mk(6'h01, 6'h38);
    w2 = mk(6'h11, 6'h30);
    w3 = mk(6'h21, 6'h28);
    w4 = mk(6'h31, 6'h20);
    go(7'h21, w1, 1'b1);
    step_in(w2);
    chk("fetch addr", fo.addr, 10'h2a2);
    e = w2;
    {e.alu, e.shc, e.sha, e.ssel} = {w1.alu, w1.shc, w1.sha, w1.ssel};
    {e.port, e.bidx} = {w1.port, w1.bidx};
    chk("k both held", k, e);
    go(7'h23, w3, 1'b1);
    chk("k micro entry", k, w3);
    step_in(w4);
    e = w4;
    {e.port, e.bidx} = {w3.port, w3.bidx};
    chk("k hold two", k, e);
    $display("t_hold done");
  endtask

  task automatic t_seqjump;
    apb(nano_dispatch_pkg::ADDR_PAGE, 1'b1, 32'h7);
    pulse(6'h20, {7'h7f, 11'h0});
    pulse(6'h08, 18'h0);
    chk("counter wrap", nsc, 10'h000);
    pulse(6'h10, 18'h0);
    chk("counter jump", nsc, w4.succ);
    pulse(6'h38, {7'h12, 11'h0});
    chk("counter priority", nsc, 10'h392);
    apb(nano_dispatch_pkg::ADDR_PAGE, 1'b1, 32'h5);
    $display("t_seqjump done");
  endtask

  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    pulse(6'h08, 18'h0);
    chk("frozen counter", nsc, 10'h392);
    @(posedge clk);
    ce <= 1'b1;
    pulse(6'h08, 18'h0);
    chk("counter step", nsc, 10'h393);
    $display("t_freeze done");
  endtask

  task automatic t_fetch;
    go(7'h30, mk(6'h0a, 6'h27), 1'b1);
    @(posedge clk);
    pend <= '1;
    pulse(6'h01, 18'h0);
    chk("fetch src", fo.src, nano_dispatch_pkg::SRC_BRANCH);
    chk("fetch addr", fo.addr, 10'h00a);
    chk("counter kept", nsc, 10'h2b0);
    chk("fetch valid", fo.valid, 1'b1);
    @(posedge clk);
    #1 chk("fetch valid", fo.valid, 1'b0);
    i_ns.mem[10'h00a] = mk(6'h0b, 6'h00);
    pulse(6'h02, 18'h0);
    pulse(6'h01, 18'h0);
    chk("fetch src", fo.src, nano_dispatch_pkg::SRC_SEQ);
    chk("fetch addr", fo.addr, 10'h2b0);
    i_ns.mem[10'h2b0] = mk(6'h0c, 6'h02);
    pulse(6'h02, 18'h0);
    @(posedge clk);
    pend <= 30'h1020;
    pulse(6'h01, 18'h0);
    chk("fetch src", fo.src, nano_dispatch_pkg::SRC_IRQ);
    chk("nano level", fo.level, 5'd5);
    i_ns.mem[10'h2b0] = mk(6'h0d, 6'h01);
    pulse(6'h02, 18'h0);
    pulse(6'h01, 18'h0);
    chk("micro level", fo.level, 5'd12);
    @(posedge clk);
    pend <= 30'h0;
    $display("t_fetch done");
  endtask

  task automatic t_timeout;
    pulse(6'h20, {7'h01, 11'h0});
    repeat (TO / 2) @(posedge clk);
    pulse(6'h20, {7'h02, 11'h0});
    c = 0;
    while (pchk !== 1'b1 && c < 3 * TO) begin
      @(posedge clk);
      #1 c++;
    end
    chk("time-out span", c >= TO - 2 && c <= TO + 2, 1'b1);
    c = 0;
    repeat (2 * TO) begin
      @(posedge clk);
      #1 c += (pchk === 1'b1);
    end
    chk("time-out once", c, 0);
    apb(nano_dispatch_pkg::ADDR_STS, 1'b0, 32'h0);
    chk("status", rq[1], 1'b1);
    $display("t_timeout done");
  endtask

  // ------------------------------------------------------------
  // run
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    errors = 0;
    n_compared = 0;
    rst_n = 1'b0;
    {dsp, jmp, seq, ldp, gat, fet} = 6'h0;
    {psel, pen, pwr, paddr, pwd} = '0;
    cs = 18'h0;
    pend = 30'h0;
    ce = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_dispatch;
    t_entry;
    t_hold;
    t_seqjump;
    t_freeze;
    t_fetch;
    t_timeout;
    close_out;
  end

  // cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    close_out;
  end
endmodule
